// File: uart_cfg.v
// UART configuration path and transmitter behind an AXI4-Lite register slave.
// Assumes a single ref_clk domain; the receiver lives elsewhere and takes rx_fifo_clear.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`include "uart_defs.vh"
`default_nettype none

module uart_cfg #(
    parameter ADDR_W  = 5,
    parameter FIFO_LG = 7
) (
    input  wire              ref_clk,
    input  wire              rst_n,
    input  wire              ce,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    output reg               tx_out,
    output reg               rx_fifo_clear
);

    localparam DEPTH = 1 << FIFO_LG;
    localparam S_IDLE  = 3'd0;
    localparam S_START = 3'd1;
    localparam S_DATA  = 3'd2;
    localparam S_PAR   = 3'd3;
    localparam S_STOP  = 3'd4;

    reg [ADDR_W-1:0]  aw_q_r;
    reg [7:0]         wd_q_r;
    reg               wlane_r;
    reg [7:0]         line_control_r;
    reg [7:0]         enhanced_feature_control_r;
    reg [7:0]         divisor_low_byte_r;
    reg [7:0]         divisor_high_byte_r;
    reg [7:0]         divisor_fraction_r;
    reg               fifo_en_r;
    reg [7:0]         mem [0:DEPTH-1];
    reg [FIFO_LG:0]   wr_ptr_r;
    reg [FIFO_LG:0]   rd_ptr_r;
    reg [15:0]        bcnt_r;
    reg [15:0]        bcnt_nxt;
    reg [`FRAC_W-1:0] facc_r;
    reg [2:0]         state_r;
    reg [3:0]         sub_r;
    reg [2:0]         bit_r;
    reg               stop2_r;
    reg               par_r;
    reg [7:0]         shift_r;
    reg [7:0]         rd_byte;

    wire [2:0]  w_idx   = aw_q_r[4:2];
    wire        w_bad   = |(aw_q_r >> 5);
    wire [2:0]  r_idx   = s_axi_araddr[4:2];
    wire        r_bad   = |(s_axi_araddr >> 5);
    wire        wr_go   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    wire        wr_en   = wr_go & wlane_r & ~w_bad;
    wire        rd_go   = s_axi_arvalid & s_axi_arready;
    wire        div_acc = line_control_r[`LINE_DIV_BIT];
    wire        enh_acc = (line_control_r == `LINE_ENH_KEY);
    wire        enh_on  = enhanced_feature_control_r[`ENH_ON_BIT];
    wire        ext_acc = div_acc & enh_on;
    wire [15:0] divisor = {divisor_high_byte_r, divisor_low_byte_r};

    wire [FIFO_LG:0] used  = wr_ptr_r - rd_ptr_r;
    wire             empty = (used == {(FIFO_LG+1){1'b0}});
    // Without the FIFO enabled the queue behaves as a single holding byte.
    wire             full  = fifo_en_r ? used[FIFO_LG] : ~empty;

    wire push = wr_en & (w_idx == `IDX_DATA) & ~div_acc & ~full; // R10
    wire fifo_ctl_wr = wr_en & (w_idx == `IDX_FIFO_ENH) & ~enh_acc;
    wire tx_clr = fifo_ctl_wr & wd_q_r[`FIFO_TXCLR_BIT]; // R09
    wire pop = (state_r == S_IDLE) & ~empty & ~tx_clr;

    wire [`FRAC_W-1:0] frac_add = enh_on ? divisor_fraction_r[`FRAC_W-1:0] : {`FRAC_W{1'b0}};
    wire [`FRAC_W:0]   facc_sum = {1'b0, facc_r} + {1'b0, frac_add};
    wire               tick = (divisor != 16'h0000) & (bcnt_r == 16'h0000);
    wire               bit_end = tick & (sub_r == `OVERSAMPLE_LAST);

    wire [2:0] last_bit = {1'b1, line_control_r[1:0]};
    wire [7:0] dmask    = 8'hFF >> (2'h3 - line_control_r[1:0]);
    wire [7:0] head     = mem[rd_ptr_r[FIFO_LG-1:0]] & dmask;

    // AXI4-Lite write channel: address and data are taken in either order,
    // the register write happens once both are held, then the response.
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_q_r        <= {ADDR_W{1'b0}};
            wd_q_r        <= 8'h00;
            wlane_r       <= 1'b0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_q_r        <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wd_q_r       <= s_axi_wdata[7:0]; // R12
                wlane_r      <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_bad ? `RESP_SLVERR : `RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Configuration registers. The line_control value decides which register a
    // shared index reaches, so the write decode below always uses the value
    // held before this write.
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_control_r             <= `RST_LINE;
            enhanced_feature_control_r <= `RST_ENH;
            divisor_low_byte_r         <= `RST_DIV_LOW;
            divisor_high_byte_r        <= `RST_DIV_HIGH;
            divisor_fraction_r         <= `RST_FRACTION;
            fifo_en_r                  <= 1'b0;
            rx_fifo_clear              <= 1'b0;
        end
        else if (ce)
        begin
            rx_fifo_clear <= 1'b0;
            if (wr_en)
            begin
                case (w_idx)
                    `IDX_DATA:
                    begin
                        if (div_acc)
                            divisor_low_byte_r <= wd_q_r; // R06
                    end
                    `IDX_DIV_HIGH:
                    begin
                        if (div_acc)
                            divisor_high_byte_r <= wd_q_r; // R06
                    end
                    `IDX_FIFO_ENH:
                    begin
                        if (enh_acc)
                            enhanced_feature_control_r <= wd_q_r; // R03 R04
                        else
                        begin
                            fifo_en_r     <= wd_q_r[`FIFO_EN_BIT]; // R09
                            rx_fifo_clear <= wd_q_r[`FIFO_RXCLR_BIT]; // R09
                        end
                    end
                    `IDX_LINE:
                        line_control_r <= wd_q_r; // R05 R08
                    `IDX_FRACTION:
                    begin
                        if (ext_acc)
                            divisor_fraction_r <= wd_q_r; // R07
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    // Read decode mirrors the write decode; unmapped indices read as zero.
    always @*
    begin
        rd_byte = 8'h00;
        case (r_idx)
            `IDX_DATA:
                rd_byte = div_acc ? divisor_low_byte_r : 8'h00; // R06
            `IDX_DIV_HIGH:
                rd_byte = div_acc ? divisor_high_byte_r : 8'h00; // R06
            `IDX_FIFO_ENH:
                rd_byte = enh_acc ? enhanced_feature_control_r : 8'h00; // R03
            `IDX_LINE:
                rd_byte = line_control_r;
            `IDX_STATUS:
            begin
                rd_byte[`STAT_THRE_BIT] = empty;
                rd_byte[`STAT_TEMT_BIT] = empty & (state_r == S_IDLE);
            end
            `IDX_FRACTION:
                rd_byte = ext_acc ? divisor_fraction_r : 8'h00; // R07
            default:
                rd_byte = 8'h00;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else if (ce)
        begin
            if (rd_go)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h000000, r_bad ? 8'h00 : rd_byte}; // R12
                s_axi_rresp   <= r_bad ? `RESP_SLVERR : `RESP_OKAY;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Transmit queue. A byte written while the queue is full is dropped.
    always @(posedge ref_clk)
    begin
        if (ce && push)
            mem[wr_ptr_r[FIFO_LG-1:0]] <= wd_q_r; // R10
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= {(FIFO_LG+1){1'b0}};
            rd_ptr_r <= {(FIFO_LG+1){1'b0}};
        end
        else if (ce)
        begin
            if (tx_clr)
                rd_ptr_r <= wr_ptr_r; // R09
            else
            begin
                if (push)
                    wr_ptr_r <= wr_ptr_r + 1'b1;
                if (pop)
                    rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    // Baud generator: one tick per 1/16 bit. The fraction is carried in an
    // accumulator so the long-run period is divisor + fraction/64 clocks,
    // at the price of one clock of jitter on individual ticks.
    always @*
    begin
        bcnt_nxt = bcnt_r - 16'h0001;
        if (divisor == 16'h0000)
            bcnt_nxt = 16'h0000;
        else if (bcnt_r == 16'h0000)
            bcnt_nxt = divisor - 16'h0001 + {15'h0000, facc_sum[`FRAC_W]}; // R01 R02
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bcnt_r <= 16'h0000;
            facc_r <= {`FRAC_W{1'b0}};
        end
        else if (ce)
        begin
            bcnt_r <= bcnt_nxt;
            if (tick)
                facc_r <= facc_sum[`FRAC_W-1:0]; // R02
        end
    end

    // Serialiser: start bit, 5 to 8 data bits LSB first, optional parity,
    // one or two stop bits, each lasting sixteen ticks.
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= S_IDLE;
            tx_out  <= 1'b1;
            sub_r   <= 4'h0;
            bit_r   <= 3'h0;
            stop2_r <= 1'b0;
            par_r   <= 1'b0;
            shift_r <= 8'h00;
        end
        else if (ce)
        begin
            if (tick)
                sub_r <= sub_r + 4'h1; // R01
            case (state_r)
                S_IDLE:
                begin
                    tx_out <= 1'b1;
                    if (pop)
                    begin
                        shift_r <= head; // R10
                        par_r   <= (^head) ^ ~line_control_r[`LINE_EVEN_BIT];
                        tx_out  <= 1'b0;
                        sub_r   <= 4'h0;
                        state_r <= S_START;
                    end
                end
                S_START:
                begin
                    if (bit_end)
                    begin
                        tx_out  <= shift_r[0];
                        shift_r <= shift_r >> 1;
                        bit_r   <= 3'h0;
                        state_r <= S_DATA;
                    end
                end
                S_DATA:
                begin
                    if (bit_end)
                    begin
                        bit_r   <= bit_r + 3'h1;
                        tx_out  <= shift_r[0];
                        shift_r <= shift_r >> 1;
                        if (bit_r == last_bit)
                        begin
                            stop2_r <= line_control_r[`LINE_STOP_BIT];
                            if (line_control_r[`LINE_PAR_BIT])
                            begin
                                tx_out  <= par_r;
                                state_r <= S_PAR;
                            end
                            else
                            begin
                                tx_out  <= 1'b1; // R05 R08
                                state_r <= S_STOP;
                            end
                        end
                    end
                end
                S_PAR:
                begin
                    if (bit_end)
                    begin
                        tx_out  <= 1'b1;
                        state_r <= S_STOP;
                    end
                end
                S_STOP:
                begin
                    if (bit_end)
                    begin
                        if (stop2_r)
                            stop2_r <= 1'b0;
                        else
                            state_r <= S_IDLE;
                    end
                end
                default:
                begin
                    state_r <= S_IDLE;
                    tx_out  <= 1'b1;
                end
            endcase
        end
    end

endmodule // uart_cfg

`default_nettype wire

// File: uart_defs.vh
// Register indices, field positions, reset values and timing constants of the UART.
// Assumes the includer uses these as 8-bit register values and 3-bit indices.
// How it works
// R01 - The baud generator makes one sixteenth-bit tick per divisor period, so divisor = clock / (16 x rate).
// R02 - A six-bit fraction adds one extra clock to the tick period on average every 64/fraction ticks.
// R03 - With line_control at 0xBF, index 2 reaches enhanced_feature_control instead of fifo_control.
// R04 - Writing 0x10 to enhanced_feature_control turns on enhanced functions, the fraction among them.
// R05 - line_control 0x93 opens the divisor and extra registers and selects 8 data bits, no parity, 1 stop.
// R06 - While divisor access is open, index 1 is divisor_high_byte and index 0 is divisor_low_byte.
// R07 - While extra access is open, index 7 is divisor_fraction, the count of sixty-fourths.
// R08 - Writing 0x13 to line_control closes the special maps and keeps 8 bits, no parity, 1 stop.
// R09 - fifo_control 0x06 clears the receive and transmit FIFOs; a later 0x01 enables the FIFOs.
// R10 - With FIFOs on, a write to tx_holding at index 0 queues the byte and sending starts by itself.
// R11 - Software should set the divisor first, then the word format, then reset the FIFOs.
// R12 - Every register is eight bits wide and selected by a three-bit index.
`ifndef UART_DEFS_VH
`define UART_DEFS_VH

`define IDX_DATA        3'h0
`define IDX_DIV_HIGH    3'h1
`define IDX_FIFO_ENH    3'h2
`define IDX_LINE        3'h3
`define IDX_STATUS      3'h5
`define IDX_FRACTION    3'h7

`define LINE_ENH_KEY    8'hBF
`define LINE_DIV_BIT    7
`define LINE_EVEN_BIT   4
`define LINE_PAR_BIT    3
`define LINE_STOP_BIT   2
`define ENH_ON_BIT      4
`define FIFO_EN_BIT     0
`define FIFO_RXCLR_BIT  1
`define FIFO_TXCLR_BIT  2
`define STAT_THRE_BIT   5
`define STAT_TEMT_BIT   6

`define RST_LINE        8'h00
`define RST_ENH         8'h00
`define RST_DIV_LOW     8'h00
`define RST_DIV_HIGH    8'h00
`define RST_FRACTION    8'h00

`define OVERSAMPLE_LAST 4'hF
`define FRAC_W          6

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// File: uart_cfg_sva.sv
// Checker for uart_cfg: register-port handshakes, clear pulse and idle serial line.
// Assumes ce stays high while the bus is busy; bound into every uart_cfg instance.
`default_nettype none
module uart_cfg_chk (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        tx_out,
    input wire logic        rx_fifo_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wrote_r;
    // The line may only leave idle once some write has completed.
    always_ff @(posedge ref_clk or negedge rst_n)
        if (!rst_n)
            wrote_r <= 1'b0;
        else if (s_axi_bvalid)
            wrote_r <= 1'b1;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_b_late;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_b_late: assert property (p_b_late) else $error("write answer late");
    property p_r_next;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_r_next: assert property (p_r_next) else $error("read answer late");
    property p_r_byte;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_r_byte: assert property (p_r_byte) else $error("read wider than a byte");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_busy: assert property (p_busy) else $error("second write accepted");
    property p_clr_pulse;
        rx_fifo_clear |=> !rx_fifo_clear;
    endproperty
    a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse too long");
    property p_clr_cause;
        rx_fifo_clear |-> $rose(s_axi_bvalid);
    endproperty
    a_clr_cause: assert property (p_clr_cause) else $error("clear without write");
    property p_idle_line;
        !wrote_r |-> tx_out;
    endproperty
    a_idle_line: assert property (p_idle_line) else $error("line left idle early");
endmodule // uart_cfg_chk

bind uart_cfg uart_cfg_chk chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .tx_out(tx_out),
    .rx_fifo_clear(rx_fifo_clear)
);
`default_nettype wire

// File: line_peer.sv
// Far-side serial receiver that decodes eight-bit frames seen on the line.
// Assumes bit_clks holds the bit time in ref_clk cycles before a frame starts.
`default_nettype none
module line_peer (
    input  wire logic       ref_clk,
    input  wire logic       line,
    input  var  int         bit_clks,
    output var  logic [7:0] got,
    output var  logic       got_stb,
    output var  logic       framing_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        got = 8'h00;
        got_stb = 1'b0;
        framing_bad = 1'b0;
        forever
        begin
            @(posedge ref_clk iff line === 1'b1);
            @(posedge ref_clk iff line === 1'b0);
            // Sampling mid-bit tolerates a first bit shortened by one tick.
            repeat (bit_clks / 2) @(posedge ref_clk);
            if (line !== 1'b0)
                framing_bad = 1'b1;
            for (int i = 0; i < 8; i++)
            begin
                repeat (bit_clks) @(posedge ref_clk);
                got[i] = line;
            end
            repeat (bit_clks) @(posedge ref_clk);
            if (line !== 1'b1)
                framing_bad = 1'b1;
            got_stb <= 1'b1;
            @(posedge ref_clk);
            got_stb <= 1'b0;
        end
    end
endmodule // line_peer
`default_nettype wire

// File: tb.sv
// Self-checking bench for uart_cfg: register traffic over AXI4-Lite and serial frames.
// Assumes line_peer decodes tx_out and the checker is bound to the design.
`include "uart_defs.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rst_n, ce, got_stb, framing_bad;
    logic [4:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, tx_out, rx_fifo_clear;
    logic [7:0]  got, d;
    logic [7:0]  rxq[$], expq[$];
    int          peer_bit = 16, fails = 0, total_checks = 0, cyc = 0, clrs = 0, c0;
    uart_cfg uut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_out(tx_out),
        .rx_fifo_clear(rx_fifo_clear));
    line_peer peer (.ref_clk(ref_clk), .line(tx_out), .bit_clks(peer_bit), .got(got),
        .got_stb(got_stb), .framing_bad(framing_bad));
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Bit time in clocks: sixteen ticks of divisor plus fraction sixty-fourths.
    function automatic int bit_clks(input int dl, input int fr);
        return 16 * dl + (16 * fr) / 64;
    endfunction
    task automatic conclude();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask
    // The wait has no limit of its own; the bench timeout ends a hang.
    task automatic wr(input logic [2:0] idx, input logic [7:0] val);
        @(posedge ref_clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, val};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        chk({30'h0, s_axi_bresp}, 32'h0);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] idx);
        @(posedge ref_clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rchk(input logic [2:0] idx, input logic [7:0] e);
        rd(idx);
        chk(v, {24'h000000, e});
    endtask
    task automatic wait_rx(input int k);
        int n;
        n = 0;
        while (rxq.size() < k && n < 40000)
        begin
            @(posedge ref_clk);
            n++;
        end
    endtask
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (rx_fifo_clear === 1'b1)
            clrs <= clrs + 1;
        if (got_stb === 1'b1)
            rxq.push_back(got);
        if (cyc == 80000)
        begin
            fails++;
            conclude();
        end
    end
    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        s_axi_awaddr = 5'h00;
        s_axi_araddr = 5'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        void'($urandom(34));
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk({31'h0, tx_out}, 32'h1);
        rchk(3'h3, `RST_LINE);
        $display("test reset done");
        // Bring-up keeps the recommended order: divisor, then format, then FIFOs.
        wr(3'h3, 8'hBF);
        wr(3'h2, 8'h10);
        rchk(3'h2, 8'h10);
        wr(3'h3, 8'h93);
        rchk(3'h3, 8'h93);
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h9C);
        wr(3'h7, 8'h10);
        rchk(3'h0, 8'h9C);
        rchk(3'h1, 8'h00);
        rchk(3'h7, 8'h10);
        wr(3'h3, 8'h13);
        rchk(3'h0, 8'h00);
        rchk(3'h7, 8'h00);
        rchk(3'h2, 8'h00);
        rchk(3'h4, 8'h00);
        $display("test bring-up done");
        c0 = clrs;
        // The pulse counter settles one edge after the write answer is seen.
        wr(3'h2, 8'h06);
        @(posedge ref_clk);
        chk(clrs - c0, 1);
        wr(3'h2, 8'h01);
        @(posedge ref_clk);
        chk(clrs - c0, 1);
        $display("test fifo reset done");
        peer_bit = bit_clks(156, 16);
        wr(3'h0, 8'hAA);
        wait_rx(1);
        chk({24'h0, rxq.pop_front()}, 32'hAA);
        $display("test first byte done");
        wr(3'h3, 8'h93);
        wr(3'h0, 8'h03);
        wr(3'h7, 8'h20);
        wr(3'h3, 8'h13);
        peer_bit = bit_clks(3, 32);
        for (int i = 0; i < 8; i++)
        begin
            d = 8'($urandom);
            expq.push_back(d);
            wr(3'h0, d);
        end
        wait_rx(8);
        while (expq.size() > 0)
            chk({24'h0, rxq.pop_front()}, {24'h0, expq.pop_front()});
        repeat (2 * peer_bit) @(posedge ref_clk);
        rd(3'h5);
        chk(v & 32'h60, 32'h60);
        $display("test random burst done");
        for (int i = 0; i < 4; i++)
            wr(3'h0, 8'(8'h5A + i));
        wr(3'h2, 8'h05);
        repeat (60 * peer_bit) @(posedge ref_clk);
        chk(rxq.size(), 1);
        chk({24'h0, rxq.pop_front()}, 32'h5A);
        chk({31'h0, framing_bad}, 32'h0);
        $display("test flush done");
        conclude();
    end
endmodule // tb
`default_nettype wire
